// ===== bench/rgm_pin_watch.sv
// far-side logic that registers the output pins and irq lines
`timescale 1ns/1ps
module rgm_pin_watch
(
   input wire logic clk_sys,
   input wire logic [4:0] irqReq,
   input wire logic pinOne,
   input wire logic pinTwo,
   output logic [6:0] seen
);
   // a synchronous receiver takes the pins on its own rising edge
   always @(posedge clk_sys)
   begin
      seen <= {irqReq, pinOne, pinTwo};
   end
endmodule // rgm_pin_watch

// ===== bench/tb_top.sv
// self-checking bench for the irq trigger and output mux bank
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic clkEn = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [4:0] errFlag = 5'h00;
   logic [11:0] srcIn = 12'h000;
   logic [4:0] irqReq;
   logic pinOne;
   logic pinTwo;
   logic [6:0] seen;
   logic [32:0] rdQ[$];
   logic [6:0] noteQ[$];
   logic [6:0] p1, p2;
   bit v1, v2;
   logic [31:0] wd;
   logic [9:0] mode = 10'h0;
   logic [3:0] selOne = 4'h0;
   logic [3:0] selTwo = 4'h0;
   logic [4:0] prevF = 5'h00;
   int mismatches = 0;
   int cmpCount = 0;
   int cycles = 0;
   integer seed;
   always #5 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////////
   // the enable is driven so that one scenario can check the freeze
   rgm_irq_gpo_mux u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .errFlag(errFlag), .txIrq(srcIn[0]),
      .rxIrq(srcIn[1]), .rxPreEmph(srcIn[2]), .rxNonAudio(srcIn[3]), .rxNonValid(srcIn[4]),
      .rxCsBit(srcIn[5]), .rxUserBit(srcIn[6]), .rxBlockClk(srcIn[7]), .rxCopyBit(srcIn[8]),
      .rxGenBit(srcIn[9]), .rxSyncClk(srcIn[10]), .txSyncClk(srcIn[11]), .irqReq(irqReq),
      .general_out_pin_one(pinOne), .general_out_pin_two(pinTwo));
   rgm_pin_watch u_watch (.clk_sys(clk_sys), .irqReq(irqReq), .pinOne(pinOne),
      .pinTwo(pinTwo), .seen(seen));
   ////////////////////////////////////////////////////////////////////////////
   // expected pin level per selector code, parity error taken from flag 2
   function automatic logic pinExp(input logic [3:0] sel, input logic [11:0] s,
      input logic [4:0] f);
      logic [15:0] t;
      t = {s[11:10], f[2], s[9:3], ~s[2:0], 3'b010};
      return t[sel];
   endfunction
   // expected requests from mode, current and previous flag samples
   function automatic logic [4:0] irqExp(input logic [9:0] m, input logic [4:0] c,
      input logic [4:0] p);
      for (int i = 0; i < 5; i++)
         case (m[2*i +: 2])
            rgm_pkg::MODE_RISE: irqExp[i] = c[i] & ~p[i];
            rgm_pkg::MODE_FALL: irqExp[i] = ~c[i] & p[i];
            rgm_pkg::MODE_LEVEL: irqExp[i] = c[i];
            default: irqExp[i] = 1'b0;
         endcase
   endfunction
   task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      cmpCount++;
      if (g !== e)
      begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic close_out();
      if (mismatches == 0 && cmpCount > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // one apb transfer, request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
      end
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      rdQ.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // flags and sources change together; the note covers irq lines and both pins
   task automatic drive(input logic [4:0] f, input logic [11:0] s);
      @(posedge clk_sys);
      errFlag <= f;
      srcIn <= s;
      noteQ.push_back({irqExp(mode, f, prevF), pinExp(selOne, s, f), pinExp(selTwo, s, f)});
      prevF = f;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // read data is taken at the completing edge, before it is released
   always @(posedge clk_sys)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk("prdata", rdQ.pop_front(), {pslverr, prdata});
   end
   // notes reach the watcher's sample two edges after the drive edge
   always @(negedge clk_sys)
   begin
      if (v2)
         chk("irq_pins", {26'h0, p2},
            {26'h0, seen});
      v2 = v1;
      p2 = p1;
      v1 = (noteQ.size() > 0);
      if (v1)
         p1 = noteQ.pop_front();
   end
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         mismatches++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      seed = 35;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      rd(rgm_pkg::ADDR_TRIG_B, 33'h0);
      rd(rgm_pkg::ADDR_TRIG_C, 33'h0);
      rd(rgm_pkg::ADDR_PIN_ONE, 33'h0);
      rd(rgm_pkg::ADDR_PIN_TWO, 33'h0);
      rd(12'h060, {1'b1, 32'h0});
      // first eight rounds put one mode on every source, then random mixes
      for (int it = 0; it < 16; it++)
      begin
         wd = $random(seed);
         if (it < 8)
            wd[7:0] = {4{it[1:0]}};
         apb(1'b1, rgm_pkg::ADDR_TRIG_B, wd);
         mode[7:0] = wd[7:0];
         rd(rgm_pkg::ADDR_TRIG_B, {25'h0, wd[7:0]});
         wd = $random(seed);
         if (it < 8)
            wd[1:0] = it[1:0];
         apb(1'b1, rgm_pkg::ADDR_TRIG_C, wd);
         mode[9:8] = wd[1:0];
         rd(rgm_pkg::ADDR_TRIG_C, {31'h0, wd[1:0]});
         wd = $random(seed);
         wd[3:0] = it[3:0];
         apb(1'b1, rgm_pkg::ADDR_PIN_ONE, wd);
         selOne = wd[3:0];
         rd(rgm_pkg::ADDR_PIN_ONE, {29'h0, wd[3:0]});
         wd = $random(seed);
         wd[3:0] = ~it[3:0];
         apb(1'b1, rgm_pkg::ADDR_PIN_TWO, wd);
         selTwo = wd[3:0];
         rd(rgm_pkg::ADDR_PIN_TWO, {29'h0, wd[3:0]});
         repeat (12) drive(5'($random(seed)), 12'($random(seed)));
         repeat (2) drive(5'h00, 12'h000);
      end
      repeat (4) @(posedge clk_sys);
      // a write to a hole must leave trigger register b alone
      apb(1'b1, 12'h060, 32'hffff_ffff);
      rd(rgm_pkg::ADDR_TRIG_B, {25'h0, mode[7:0]});
      // with the enable low, new flags and sources must not reach the outputs
      @(posedge clk_sys);
      clkEn <= 1'b0;
      errFlag <= 5'h1f;
      srcIn <= 12'hfff;
      repeat (3) @(posedge clk_sys);
      wd[6:0] = {irqExp(mode, 5'h00, 5'h00), pinExp(selOne, 12'h000, 5'h00),
         pinExp(selTwo, 12'h000, 5'h00)};
      chk("frozen", {26'h0, wd[6:0]}, {26'h0, irqReq, pinOne, pinTwo});
      @(posedge clk_sys);
      errFlag <= 5'h00;
      srcIn <= 12'h000;
      clkEn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      close_out();
   end
endmodule // tb_top

// ===== rtl/rgm_irq_gpo_mux.sv
// receiver irq trigger modes and general-purpose output mux, apb register bank
//
// How it works
// - two-bit trigger mode for channel status crc
// - two-bit trigger mode for parity error
// - two-bit trigger mode for validity error
// - two-bit trigger mode for biphase error
// - 00 rise default, 01 fall, 10 level
// - slip mode in low bits, rest zero
// - first pin selector low nibble, rest zero
// - 0000 low default, 0001 high, 0010 reserved
// - 0011 tx irq low, 0100 rx irq low
// - 0101 pin low on pre-emphasis
// - 0110 non-audio high, 0111 non-valid high
// - channel status, user data, block clock
// - 1011 copy bit passed through
// - 1100 generation bit passed through
// - parity error, rx sync, tx sync clocks
// - second pin selector low nibble, rest zero
// - second pin shares table, low default
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module rgm_irq_gpo_mux
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [4:0] errFlag,
   input wire logic txIrq,
   input wire logic rxIrq,
   input wire logic rxPreEmph,
   input wire logic rxNonAudio,
   input wire logic rxNonValid,
   input wire logic rxCsBit,
   input wire logic rxUserBit,
   input wire logic rxBlockClk,
   input wire logic rxCopyBit,
   input wire logic rxGenBit,
   input wire logic rxSyncClk,
   input wire logic txSyncClk,
   output logic [4:0] irqReq,
   output logic general_out_pin_one,
   output logic general_out_pin_two
);

   rgm_pkg::rgm_state_s st;
   rgm_pkg::rgm_state_s next_st;
   logic [9:0] trigAll;
   logic [4:0] irqNext;
   logic [3:0] selArr [rgm_pkg::NUM_PIN];
   logic [1:0] pinNext;
   logic acc;
   logic wrDone;
   logic mapped;

   ////////////////////////////////////////////////////////////////////////
   // output selection, one table shared by both pins

   function automatic logic pickSource(input logic [3:0] sel);
      logic v;
      v = 1'b0;
      case (sel)
         rgm_pkg::SEL_LOW: v = 1'b0;
         rgm_pkg::SEL_HIGH: v = 1'b1;
         rgm_pkg::SEL_RSVD: v = 1'b0;
         rgm_pkg::SEL_TX_IRQ: v = ~txIrq;
         rgm_pkg::SEL_RX_IRQ: v = ~rxIrq;
         rgm_pkg::SEL_PREEMPH: v = ~rxPreEmph;
         rgm_pkg::SEL_NON_AUDIO: v = rxNonAudio;
         rgm_pkg::SEL_NON_VALID: v = rxNonValid;
         rgm_pkg::SEL_CS_BIT: v = rxCsBit;
         rgm_pkg::SEL_USER_BIT: v = rxUserBit;
         rgm_pkg::SEL_BLOCK_CLK: v = rxBlockClk;
         rgm_pkg::SEL_COPY_BIT: v = rxCopyBit;
         rgm_pkg::SEL_GEN_BIT: v = rxGenBit;
         rgm_pkg::SEL_PARITY: v = errFlag[rgm_pkg::SRC_PARITY];
         rgm_pkg::SEL_RX_SYNC: v = rxSyncClk;
         rgm_pkg::SEL_TX_SYNC: v = txSyncClk;
         default: v = 1'b0;
      endcase
      return v;
   endfunction

   assign selArr[0] = st.selOne;
   assign selArr[1] = st.selTwo;

   // each pin goes through one flop, so sync clocks lag by one cycle
   generate
      for (genvar p = 0; p < rgm_pkg::NUM_PIN; p++)
      begin : g_pin
         // always_comb also wakes on the sources that the function reads,
         // which a continuous assign with only the selector would miss
         always_comb
         begin
            pinNext[p] = pickSource(selArr[p]);
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // trigger decode per error source

   assign trigAll = {st.trigC, st.trigB};

   // flags come from receiver logic on this clock, so no synchroniser;
   // a reserved mode raises nothing rather than guessing a meaning
   generate
      for (genvar i = 0; i < rgm_pkg::NUM_SRC; i++)
      begin : g_src
         always_comb
         begin
            case (trigAll[2*i +: 2])
               rgm_pkg::MODE_RISE: irqNext[i] = errFlag[i] & ~st.prevFlag[i];
               rgm_pkg::MODE_FALL: irqNext[i] = ~errFlag[i] & st.prevFlag[i];
               rgm_pkg::MODE_LEVEL: irqNext[i] = errFlag[i];
               default: irqNext[i] = 1'b0;
            endcase
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // apb decode: one wait state, the access completes on the ack edge

   assign acc = psel & penable;
   assign wrDone = acc & st.ack & pwrite;
   assign mapped = (paddr == rgm_pkg::ADDR_TRIG_B) || (paddr == rgm_pkg::ADDR_TRIG_C)
      || (paddr == rgm_pkg::ADDR_PIN_ONE) || (paddr == rgm_pkg::ADDR_PIN_TWO);

   // next state of the whole bank
   always_comb
   begin
      next_st = st;
      next_st.prevFlag = errFlag;
      next_st.irqReq = irqNext;
      next_st.pinOne = pinNext[0];
      next_st.pinTwo = pinNext[1];
      case (st.phase)
         rgm_pkg::PH_IDLE:
         begin
            next_st.ack = 1'b0;
            next_st.slvErr = 1'b0;
            if (acc)
            begin
               next_st.phase = rgm_pkg::PH_ACK;
               next_st.ack = 1'b1;
               next_st.slvErr = ~mapped;
               next_st.rdData = 32'h0000_0000;
               if (!pwrite)
               begin
                  // unused bits above each field read as zero
                  case (paddr)
                     rgm_pkg::ADDR_TRIG_B: next_st.rdData = {24'h000000, st.trigB};
                     rgm_pkg::ADDR_TRIG_C: next_st.rdData = {30'h0, st.trigC};
                     rgm_pkg::ADDR_PIN_ONE: next_st.rdData = {28'h0, st.selOne};
                     rgm_pkg::ADDR_PIN_TWO: next_st.rdData = {28'h0, st.selTwo};
                     default: next_st.rdData = 32'h0000_0000;
                  endcase
               end
            end
         end
         rgm_pkg::PH_ACK:
         begin
            next_st.phase = rgm_pkg::PH_IDLE;
            next_st.ack = 1'b0;
            next_st.slvErr = 1'b0;
         end
         default:
         begin
            next_st.phase = rgm_pkg::PH_IDLE;
            next_st.ack = 1'b0;
         end
      endcase
      // writes land on the edge that samples pready high
      if (wrDone)
      begin
         case (paddr)
            rgm_pkg::ADDR_TRIG_B: next_st.trigB = pwdata[7:0];
            rgm_pkg::ADDR_TRIG_C: next_st.trigC = pwdata[1:0];
            rgm_pkg::ADDR_PIN_ONE: next_st.selOne = pwdata[3:0];
            rgm_pkg::ADDR_PIN_TWO: next_st.selTwo = pwdata[3:0];
            default: next_st.trigB = st.trigB;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; clkEn low freezes everything, bus included

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st.trigB <= rgm_pkg::RST_TRIG_B;
         st.trigC <= rgm_pkg::RST_TRIG_C;
         st.selOne <= rgm_pkg::RST_SEL;
         st.selTwo <= rgm_pkg::RST_SEL;
         st.prevFlag <= 5'h00;
         st.irqReq <= 5'h00;
         st.pinOne <= 1'b0;
         st.pinTwo <= 1'b0;
         st.rdData <= 32'h0000_0000;
         st.ack <= 1'b0;
         st.slvErr <= 1'b0;
         st.phase <= rgm_pkg::PH_IDLE;
      end
      else if (clkEn)
      begin
         st <= next_st;
      end
   end

   assign prdata = st.rdData;
   assign pready = st.ack;
   assign pslverr = st.slvErr;
   assign irqReq = st.irqReq;
   assign general_out_pin_one = st.pinOne;
   assign general_out_pin_two = st.pinTwo;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   sequence apbWrite(logic [11:0] a);
      clkEn && psel && penable && pready && pwrite && paddr == a;
   endsequence

   sequence apbReadReq(logic [11:0] a);
      clkEn && psel && penable && !pready && !pwrite && paddr == a;
   endsequence

   // a pin selector seen at one code on an enabled edge
   sequence pinOneSel(logic [3:0] c);
      clkEn && st.selOne == c;
   endsequence

   sequence pinTwoSel(logic [3:0] c);
      clkEn && st.selTwo == c;
   endsequence

   trig_b_store_a: assert property (apbWrite(rgm_pkg::ADDR_TRIG_B) |=>
      st.trigB == $past(pwdata[7:0]))
      else $error("trigger register b not stored");

   cs_crc_rise_a: assert property (clkEn && trigAll[7:6] == rgm_pkg::MODE_RISE
      && $rose(errFlag[rgm_pkg::SRC_CS_CRC]) && $past(clkEn) |=> irqReq[rgm_pkg::SRC_CS_CRC])
      else $error("crc rising edge gave no request");

   parity_fall_a: assert property (clkEn && trigAll[5:4] == rgm_pkg::MODE_FALL
      && !errFlag[rgm_pkg::SRC_PARITY] && st.prevFlag[rgm_pkg::SRC_PARITY]
      |=> irqReq[rgm_pkg::SRC_PARITY])
      else $error("parity falling edge gave no request");

   validity_level_a: assert property (clkEn && trigAll[3:2] == rgm_pkg::MODE_LEVEL
      |=> irqReq[rgm_pkg::SRC_VALIDITY] == $past(errFlag[rgm_pkg::SRC_VALIDITY]))
      else $error("level mode request does not follow flag");

   edge_once_a: assert property (clkEn && trigAll[1:0] == rgm_pkg::MODE_RISE
      && irqReq[rgm_pkg::SRC_BIPHASE] && errFlag[rgm_pkg::SRC_BIPHASE]
      |=> !irqReq[rgm_pkg::SRC_BIPHASE])
      else $error("edge request lasted more than one cycle");

   reserved_mode_a: assert property (clkEn && trigAll[9:8] == rgm_pkg::MODE_RSVD
      |=> !irqReq[rgm_pkg::SRC_SLIP])
      else $error("reserved mode raised a request");

   slip_read_a: assert property (apbReadReq(rgm_pkg::ADDR_TRIG_C) ##1 clkEn
      |-> prdata[31:2] == 30'h0)
      else $error("unused bits of register c not zero");

   pin_force_a: assert property (clkEn && st.selOne == rgm_pkg::SEL_HIGH
      |=> general_out_pin_one)
      else $error("forced high pin reads low");

   pin_irq_low_a: assert property (clkEn && st.selOne == rgm_pkg::SEL_RX_IRQ
      |=> general_out_pin_one == !$past(rxIrq))
      else $error("pin does not show inverted receiver irq");

   preemph_low_a: assert property (clkEn && st.selTwo == rgm_pkg::SEL_PREEMPH
      && rxPreEmph |=> !general_out_pin_two)
      else $error("pin not low with pre-emphasis");

   pin_two_table_a: assert property (clkEn && st.selTwo == rgm_pkg::SEL_COPY_BIT
      |=> general_out_pin_two == $past(rxCopyBit))
      else $error("second pin does not carry copy bit");

   bus_answer_a: assert property (clkEn && psel && penable && !pready ##1 clkEn
      |-> pready)
      else $error("bus access not answered in one wait state");

   ////////////////////////////////////////////////////////////////////////
   // register stores, biphase fall and slip level modes, the rest of the pin table and the freeze

   trig_c_store_a: assert property (apbWrite(rgm_pkg::ADDR_TRIG_C)
      |=> st.trigC == $past(pwdata[1:0]))
      else $error("trigger register c not stored");

   sel_one_store_a: assert property (apbWrite(rgm_pkg::ADDR_PIN_ONE)
      |=> st.selOne == $past(pwdata[3:0]))
      else $error("first pin selector not stored");

   sel_two_store_a: assert property (apbWrite(rgm_pkg::ADDR_PIN_TWO)
      |=> st.selTwo == $past(pwdata[3:0]))
      else $error("second pin selector not stored");

   biphase_fall_a: assert property (clkEn && trigAll[1:0] == rgm_pkg::MODE_FALL
      && $fell(errFlag[rgm_pkg::SRC_BIPHASE]) && $past(clkEn) |=> irqReq[rgm_pkg::SRC_BIPHASE])
      else $error("biphase falling edge gave no request");

   slip_level_a: assert property (clkEn && trigAll[9:8] == rgm_pkg::MODE_LEVEL
      |=> irqReq[rgm_pkg::SRC_SLIP] == $past(errFlag[rgm_pkg::SRC_SLIP]))
      else $error("slip level request does not follow flag");

   pin_low_a: assert property (pinOneSel(rgm_pkg::SEL_LOW)
      |=> !general_out_pin_one)
      else $error("forced low pin reads high");

   pin_rsvd_a: assert property (pinTwoSel(rgm_pkg::SEL_RSVD)
      |=> !general_out_pin_two)
      else $error("reserved code did not drive low");

   pin_two_high_a: assert property (pinTwoSel(rgm_pkg::SEL_HIGH)
      |=> general_out_pin_two)
      else $error("second pin forced high reads low");

   pin_tx_irq_a: assert property (pinTwoSel(rgm_pkg::SEL_TX_IRQ)
      |=> general_out_pin_two == !$past(txIrq))
      else $error("pin does not show inverted transmitter irq");

   non_audio_a: assert property (pinOneSel(rgm_pkg::SEL_NON_AUDIO)
      |=> general_out_pin_one == $past(rxNonAudio))
      else $error("pin does not show non-audio flag");

   non_valid_a: assert property (pinTwoSel(rgm_pkg::SEL_NON_VALID)
      |=> general_out_pin_two == $past(rxNonValid))
      else $error("pin does not show non-valid flag");

   cs_bit_a: assert property (pinOneSel(rgm_pkg::SEL_CS_BIT)
      |=> general_out_pin_one == $past(rxCsBit))
      else $error("pin does not carry channel status bit");

   user_bit_a: assert property (pinTwoSel(rgm_pkg::SEL_USER_BIT)
      |=> general_out_pin_two == $past(rxUserBit))
      else $error("pin does not carry user data bit");

   block_clk_a: assert property (pinOneSel(rgm_pkg::SEL_BLOCK_CLK)
      |=> general_out_pin_one == $past(rxBlockClk))
      else $error("pin does not carry block start clock");

   copy_bit_a: assert property (pinOneSel(rgm_pkg::SEL_COPY_BIT)
      |=> general_out_pin_one == $past(rxCopyBit))
      else $error("first pin does not carry copy bit");

   gen_bit_a: assert property (pinOneSel(rgm_pkg::SEL_GEN_BIT)
      |=> general_out_pin_one == $past(rxGenBit))
      else $error("pin does not carry generation bit");

   parity_pin_a: assert property (pinTwoSel(rgm_pkg::SEL_PARITY)
      |=> general_out_pin_two == $past(errFlag[rgm_pkg::SRC_PARITY]))
      else $error("pin does not show parity error");

   rx_sync_a: assert property (pinOneSel(rgm_pkg::SEL_RX_SYNC)
      |=> general_out_pin_one == $past(rxSyncClk))
      else $error("pin does not carry receiver sync clock");

   tx_sync_a: assert property (pinTwoSel(rgm_pkg::SEL_TX_SYNC)
      |=> general_out_pin_two == $past(txSyncClk))
      else $error("pin does not carry transmitter sync clock");

   // a frozen edge baseline lets a flag change made while frozen fire its edge on the first enabled edge
   frozen_state_a: assert property (!clkEn
      |=> $stable(st))
      else $error("state moved with the enable low");

endmodule // rgm_irq_gpo_mux

// ===== rtl/rgm_pkg.sv
// constants, types and register map of the irq trigger and output mux bank
package rgm_pkg;
   // register indices; the byte address is four times the index
   localparam logic [7:0] IDX_TRIG_B = 8'h19;
   localparam logic [7:0] IDX_TRIG_C = 8'h1a;
   localparam logic [7:0] IDX_PIN_ONE = 8'h1b;
   localparam logic [7:0] IDX_PIN_TWO = 8'h1c;
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_TRIG_B = {2'h0, IDX_TRIG_B, 2'h0};
   localparam logic [11:0] ADDR_TRIG_C = {2'h0, IDX_TRIG_C, 2'h0};
   localparam logic [11:0] ADDR_PIN_ONE = {2'h0, IDX_PIN_ONE, 2'h0};
   localparam logic [11:0] ADDR_PIN_TWO = {2'h0, IDX_PIN_TWO, 2'h0};
   // error sources; source i uses trigger bits [2i+1:2i] of {trigC, trigB}
   localparam int SRC_BIPHASE = 0;
   localparam int SRC_VALIDITY = 1;
   localparam int SRC_PARITY = 2;
   localparam int SRC_CS_CRC = 3;
   localparam int SRC_SLIP = 4;
   localparam int NUM_SRC = 5;
   localparam int NUM_PIN = 2;
   // field positions
   localparam int BIPHASE_LSB = 0;
   localparam int VALIDITY_LSB = 2;
   localparam int PARITY_LSB = 4;
   localparam int CS_CRC_LSB = 6;
   localparam int SLIP_LSB = 0;
   localparam int SEL_LSB = 0;
   // reset values
   localparam logic [7:0] RST_TRIG_B = 8'h00;
   localparam logic [1:0] RST_TRIG_C = 2'h0;
   localparam logic [3:0] RST_SEL = 4'h0;
   // trigger mode encoding
   localparam logic [1:0] MODE_RISE = 2'h0;
   localparam logic [1:0] MODE_FALL = 2'h1;
   localparam logic [1:0] MODE_LEVEL = 2'h2;
   localparam logic [1:0] MODE_RSVD = 2'h3;
   // output selector encoding
   localparam logic [3:0] SEL_LOW = 4'h0;
   localparam logic [3:0] SEL_HIGH = 4'h1;
   localparam logic [3:0] SEL_RSVD = 4'h2;
   localparam logic [3:0] SEL_TX_IRQ = 4'h3;
   localparam logic [3:0] SEL_RX_IRQ = 4'h4;
   localparam logic [3:0] SEL_PREEMPH = 4'h5;
   localparam logic [3:0] SEL_NON_AUDIO = 4'h6;
   localparam logic [3:0] SEL_NON_VALID = 4'h7;
   localparam logic [3:0] SEL_CS_BIT = 4'h8;
   localparam logic [3:0] SEL_USER_BIT = 4'h9;
   localparam logic [3:0] SEL_BLOCK_CLK = 4'ha;
   localparam logic [3:0] SEL_COPY_BIT = 4'hb;
   localparam logic [3:0] SEL_GEN_BIT = 4'hc;
   localparam logic [3:0] SEL_PARITY = 4'hd;
   localparam logic [3:0] SEL_RX_SYNC = 4'he;
   localparam logic [3:0] SEL_TX_SYNC = 4'hf;
   typedef enum logic [0:0] {PH_IDLE, PH_ACK} rgm_phase_e;
   typedef struct packed {
      logic [7:0] trigB;
      logic [1:0] trigC;
      logic [3:0] selOne;
      logic [3:0] selTwo;
      logic [4:0] prevFlag;
      logic [4:0] irqReq;
      logic pinOne;
      logic pinTwo;
      logic [31:0] rdData;
      logic ack;
      logic slvErr;
      rgm_phase_e phase;
   } rgm_state_s;
endpackage
